// [bench/tb_stack_pointer_ext_ops.sv]
// Self-checking bench for the extended pointer and stack instruction executor
`timescale 1ns/1ps
module tb_stack_pointer_ext_ops;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_extended_set_config_bit = 1'b1;
  logic i_instr_valid = 1'b0;
  logic [15:0] i_instr_word = 16'h0000;
  logic [20:0] i_pc = 21'h000000;
  logic [7:0] i_working_register = 8'h00;
  logic [7:0] i_prog_counter_latch_high = 8'h00;
  logic [7:0] i_prog_counter_latch_upper = 8'h00;
  logic [20:0] i_top_of_return_stack = 21'h000000;
  logic [7:0] i_mem_rd_data = 8'h00;
  logic o_instr_taken;
  logic o_busy;
  logic o_pc_load;
  logic [20:0] o_pc_value;
  ext_ops_pkg::stack_op_t o_stack_op;
  ext_ops_pkg::mem_rd_t o_mem_rd;
  ext_ops_pkg::mem_wr_t o_mem_wr;
  logic [11:0] o_fsr0;
  logic [11:0] o_fsr1;
  logic [11:0] o_software_stack_pointer;
  logic [11:0] ep [3] = '{12'h000, 12'h000, 12'h000}; // Expected pointers
  logic [11:0] xsrc = 12'h000;                        // Expected move source
  logic [20:0] tgt;
  int n_errors = 0;
  int n_tests = 0;

  stack_pointer_ext_ops dut (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_extended_set_config_bit(i_extended_set_config_bit),
    .i_instr_valid(i_instr_valid),
    .i_instr_word(i_instr_word),
    .i_pc(i_pc),
    .i_working_register(i_working_register),
    .i_prog_counter_latch_high(i_prog_counter_latch_high),
    .i_prog_counter_latch_upper(i_prog_counter_latch_upper),
    .i_top_of_return_stack(i_top_of_return_stack),
    .i_mem_rd_data(i_mem_rd_data),
    .o_instr_taken(o_instr_taken),
    .o_busy(o_busy),
    .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value),
    .o_stack_op(o_stack_op),
    .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr),
    .o_fsr0(o_fsr0),
    .o_fsr1(o_fsr1),
    .o_software_stack_pointer(o_software_stack_pointer)
  );

  always #25 i_sys_clk = ~i_sys_clk;

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  function automatic logic is_ind(input logic [11:0] a);
    return (a >= 12'hFDB && a <= 12'hFDF) || (a >= 12'hFE3 && a <= 12'hFE7) ||
      (a >= 12'hFEB && a <= 12'hFEF);
  endfunction : is_ind

  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One instruction cycle; inputs change 4 ns after the edge so no race with sampling
  task automatic step(input logic v, input logic [15:0] w, input logic tk);
    i_instr_valid = v;
    i_instr_word = w;
    #1;
    chk("taken", o_instr_taken, tk);
    if (tk && w[15:7] == ext_ops_pkg::OPC_MOVE_INDEXED_TO_ABSOLUTE_HI) begin
      chk("rd_req", o_mem_rd.req, !is_ind(xsrc));
      chk("rd_addr", o_mem_rd.addr, xsrc);
    end
    @(posedge i_sys_clk);
    #4;
  endtask : step

  task automatic ptrs();
    chk("fsr0", o_fsr0, ep[0]);
    chk("fsr1", o_fsr1, ep[1]);
    chk("sp", o_software_stack_pointer, ep[2]);
  endtask : ptrs

  // ---------------------------------------------------------------
  // Operations
  // ---------------------------------------------------------------
  task automatic do_add(input logic [1:0] sel, input logic [5:0] lit);
    logic [1:0] ix;
    ix = (sel == 2'h3) ? 2'h2 : sel;
    ep[ix] = ep[ix] + {6'h00, lit};
    step(1'b1, {ext_ops_pkg::OPC_ADD_PTR_HI, sel, lit}, 1'b1);
    ptrs();
    chk("busy", o_busy, sel == 2'h3);
    chk("pc_load", o_pc_load, sel == 2'h3);
    if (sel == 2'h3) begin
      chk("pc_value", o_pc_value, i_top_of_return_stack);
      chk("pop", o_stack_op.pop, 1'b1);
      step(1'b1, 16'hE801, 1'b0);
      ptrs();
    end
  endtask : do_add

  task automatic do_call();
    tgt = {i_prog_counter_latch_upper[4:0], i_prog_counter_latch_high, i_working_register};
    step(1'b1, ext_ops_pkg::OPC_CALL_WORKING_REGISTER, 1'b1);
    chk("push", o_stack_op.push, 1'b1);
    chk("push_val", o_stack_op.push_val, i_pc + 21'h000002);
    chk("pc_load", o_pc_load, 1'b1);
    chk("pc_value", o_pc_value, tgt);
    chk("busy", o_busy, 1'b1);
    step(1'b1, 16'hE801, 1'b0);
    chk("busy_end", o_busy, 1'b0);
    ptrs();
  endtask : do_call

  task automatic do_move(input logic [6:0] ofs, input logic [11:0] dst, input logic [7:0] rd);
    xsrc = ep[2] + {5'h00, ofs};
    i_mem_rd_data = rd;
    step(1'b1, {ext_ops_pkg::OPC_MOVE_INDEXED_TO_ABSOLUTE_HI, ofs}, 1'b1);
    chk("busy", o_busy, 1'b1);
    chk("we_early", o_mem_wr.we, 1'b0);
    step(1'b1, {ext_ops_pkg::OPC_SECOND_WORD, dst}, 1'b1);
    chk("we", o_mem_wr.we, 1'b1);
    chk("wr_addr", o_mem_wr.addr, dst);
    chk("wr_data", o_mem_wr.data, is_ind(xsrc) ? 8'h00 : rd);
  endtask : do_move

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(94803));
    repeat (3) @(posedge i_sys_clk);
    #5 i_rst_n = 1'b1;
    repeat (6) step(1'b0, 16'h0000, 1'b0);
    // Extended words must be ignored while the config bit is clear
    i_extended_set_config_bit = 1'b0;
    repeat (4) step(1'b0, 16'h0000, 1'b0);
    step(1'b1, 16'hE805, 1'b0);
    ptrs();
    i_extended_set_config_bit = 1'b1;
    repeat (4) step(1'b0, 16'h0000, 1'b0);
    do_add(2'h0, 6'h3F);
    do_add(2'h1, 6'h00);
    // Walk the stack pointer to FC0 so offsets sweep the indirect block
    repeat (64) do_add(2'h2, 6'h3F);
    i_top_of_return_stack = 21'h1FFFFF;
    do_add(2'h3, 6'h00);
    i_pc = 21'h1FFFFF;
    i_working_register = 8'hFF;
    i_prog_counter_latch_upper = 8'hFF;
    do_call();
    do_move(7'h00, 12'h000, 8'h5A);
    // Destinations stay below F80 so no program counter or stack byte is hit
    for (int o = 1; o < 128; o++) do_move(7'(o), 12'($urandom % 3968), 8'($urandom) | 8'h80);
    repeat (40) begin
      i_pc = 21'($urandom);
      i_working_register = 8'($urandom);
      i_prog_counter_latch_high = 8'($urandom);
      i_prog_counter_latch_upper = 8'($urandom);
      i_top_of_return_stack = 21'($urandom);
      case ($urandom % 3)
        0: do_add(2'($urandom), 6'($urandom));
        1: do_call();
        default: do_move(7'($urandom), 12'($urandom % 3968), 8'($urandom));
      endcase
    end
    step(1'b0, 16'h0000, 1'b0);
    end_of_test();
  end

  // Watchdog so a stuck handshake cannot hang the run
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_errors++;
    end_of_test();
  end
endmodule : tb_stack_pointer_ext_ops

// [verilog/ext_ops_pkg.sv]
// Shared constants and carriers for the extended pointer/stack instruction executor
package ext_ops_pkg;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_ADD_PTR_HI = 8'hE8;   // add_literal_to_pointer high byte
  localparam logic [15:0] OPC_CALL_WORKING_REGISTER = 16'h0014; // call_via_work_reg
  localparam logic [8:0] OPC_MOVE_INDEXED_TO_ABSOLUTE_HI = 9'h1D6;    // move_indexed_to_absolute, bits 15..7
  localparam logic [3:0] OPC_SECOND_WORD = 4'hF;   // second word prefix
  localparam logic [1:0] SEL_STACK_PTR = 2'h3;     // pointer select for software stack ptr
  localparam int PTR_SEL_LSB = 6;
  localparam int PTR_SEL_MSB = 7;
  localparam int LIT6_MSB = 5;
  localparam int OFS7_MSB = 6;
  localparam int ADDR_MSB = 11;
  localparam logic [20:0] PC_RET_STEP = 21'h000002; // return address step
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Indirect-addressing registers (plain defaults)
  localparam logic [11:0] IND_LO = 12'hFDB;
  localparam logic [11:0] IND_HI = 12'hFEF;
  localparam logic [11:0] IND_MASK_LO = 12'hFDB;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic [11:0] addr;
  } mem_rd_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic push;
    logic [20:0] push_val;
    logic pop;
  } stack_op_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_NOP = 2'b01,
    ST_MOVE2 = 2'b10
  } exec_state_t;
endpackage : ext_ops_pkg

// [verilog/stack_pointer_ext_ops.sv]
// Executor for pointer-add, add-and-return, call through working register and indexed move
`timescale 1ns/1ps

// Contract
// RULE_01: Extended ops only when config bit set
// RULE_02: Add six-bit literal to selected pointer
// RULE_03: Select three adds to software stack pointer
// RULE_04: Then return: pc loaded from stack top
// RULE_05: Add-and-return takes two cycles, second idle
// RULE_06: Call through working register, two cycles
// RULE_07: Push pc plus two onto stack
// RULE_08: Working register replaces pc low byte
// RULE_09: Latch high/upper copied into pc bytes
// RULE_10: Second call cycle idle while fetching target
// RULE_11: Call never touches work, status, bank
// RULE_12: Move is two words, two cycles
// RULE_13: Source equals stack pointer plus offset
// RULE_14: Destination from literal, copy byte, no flags
// RULE_15: Both addresses span full 12-bit space
// RULE_16: Software avoids pc low/stack-top destinations
// RULE_17: Indirect source address reads as zero
module stack_pointer_ext_ops (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_extended_set_config_bit,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr_word,
  input wire logic [20:0] i_pc,
  input wire logic [7:0] i_working_register,
  input wire logic [7:0] i_prog_counter_latch_high,
  input wire logic [7:0] i_prog_counter_latch_upper,
  input wire logic [20:0] i_top_of_return_stack,
  input wire logic [7:0] i_mem_rd_data,
  output logic o_instr_taken,
  output logic o_busy,
  output logic o_pc_load,
  output logic [20:0] o_pc_value,
  output ext_ops_pkg::stack_op_t o_stack_op,
  output ext_ops_pkg::mem_rd_t o_mem_rd,
  output ext_ops_pkg::mem_wr_t o_mem_wr,
  output logic [11:0] o_fsr0,
  output logic [11:0] o_fsr1,
  output logic [11:0] o_software_stack_pointer
);

  // ---------------------------------------------------------------
  // Reset release and config strap synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_ff, rst_sync_ff, rst_n;
  logic cfg_meta_ff, cfg_sync_ff;

  // Reset asserts at once and releases on the clock
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // The config bit is a pin from outside; two stages before decode
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_meta_ff <= 1'b0;
      cfg_sync_ff <= 1'b0;
    end else begin
      cfg_meta_ff <= i_extended_set_config_bit;
      cfg_sync_ff <= cfg_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  ext_ops_pkg::exec_state_t state_ff, nxt_state;
  logic [11:0] ptr_ff [3];
  logic [7:0] move_byte_ff, nxt_move_byte;
  logic [11:0] nxt_ptr [3];

  wire idle = (state_ff == ext_ops_pkg::ST_FETCH);
  wire take = idle && i_instr_valid && cfg_sync_ff; // [RULE_01]
  wire [1:0] ptr_sel = i_instr_word[ext_ops_pkg::PTR_SEL_MSB:ext_ops_pkg::PTR_SEL_LSB];
  wire [11:0] lit6 = {6'h00, i_instr_word[ext_ops_pkg::LIT6_MSB:0]};
  wire is_add = take && (i_instr_word[15:8] == ext_ops_pkg::OPC_ADD_PTR_HI); // [RULE_02]
  wire is_add_ret = is_add && (ptr_sel == ext_ops_pkg::SEL_STACK_PTR); // [RULE_03]
  wire is_call = take && (i_instr_word == ext_ops_pkg::OPC_CALL_WORKING_REGISTER); // [RULE_06]
  wire is_move = take && (i_instr_word[15:7] == ext_ops_pkg::OPC_MOVE_INDEXED_TO_ABSOLUTE_HI); // [RULE_12]
  wire is_second = (state_ff == ext_ops_pkg::ST_MOVE2) && i_instr_valid
    && (i_instr_word[15:12] == ext_ops_pkg::OPC_SECOND_WORD);

  // Source is stack pointer plus unsigned 7-bit offset, wrapping in 12 bits
  wire [11:0] src_addr = ptr_ff[2]
    + {5'h00, i_instr_word[ext_ops_pkg::OFS7_MSB:0]}; // [RULE_13] [RULE_15]
  wire src_indirect = (src_addr >= ext_ops_pkg::IND_LO) && (src_addr <= ext_ops_pkg::IND_HI)
    && ((src_addr & 12'h007) >= 12'h003) && ((src_addr & 12'h007) <= 12'h007);
  // Indirect source yields zero instead of a nested access
  wire [7:0] src_byte = src_indirect ? ext_ops_pkg::BYTE_ZERO : i_mem_rd_data; // [RULE_17]

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_move_byte = move_byte_ff;
    nxt_ptr[0] = ptr_ff[0];
    nxt_ptr[1] = ptr_ff[1];
    nxt_ptr[2] = ptr_ff[2];
    case (state_ff)
      ext_ops_pkg::ST_FETCH: begin
        if (is_add) begin
          // Flags untouched: no status output exists
          nxt_ptr[ptr_sel == ext_ops_pkg::SEL_STACK_PTR ? 2 : ptr_sel] =
            ptr_ff[ptr_sel == ext_ops_pkg::SEL_STACK_PTR ? 2 : ptr_sel] + lit6; // [RULE_02]
          if (is_add_ret) begin
            nxt_state = ext_ops_pkg::ST_NOP; // [RULE_05]
          end
        end else if (is_call) begin
          nxt_state = ext_ops_pkg::ST_NOP; // [RULE_10]
        end else if (is_move) begin
          nxt_move_byte = src_byte;
          nxt_state = ext_ops_pkg::ST_MOVE2;
        end
      end
      ext_ops_pkg::ST_NOP: begin
        nxt_state = ext_ops_pkg::ST_FETCH;
      end
      ext_ops_pkg::ST_MOVE2: begin
        if (is_second) begin
          nxt_state = ext_ops_pkg::ST_FETCH;
        end
      end
      default: begin
        nxt_state = ext_ops_pkg::ST_FETCH;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State and move-byte registers, plus one pointer register per pointer via generate
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ext_ops_pkg::ST_FETCH;
      move_byte_ff <= ext_ops_pkg::BYTE_ZERO;
    end else begin
      state_ff <= nxt_state;
      move_byte_ff <= nxt_move_byte;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ptr_ff[gi] <= ext_ops_pkg::PTR_RESET;
        end else begin
          ptr_ff[gi] <= nxt_ptr[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registered side effects toward pc, stack and memory
  // ---------------------------------------------------------------
  logic pc_load_ff;
  logic [20:0] pc_value_ff;
  ext_ops_pkg::stack_op_t stack_ff;
  ext_ops_pkg::mem_wr_t wr_ff;

  wire [20:0] call_target = {i_prog_counter_latch_upper[4:0], i_prog_counter_latch_high,
    i_working_register}; // [RULE_08] [RULE_09]

  // The call leaves working, status and bank registers alone: it only drives pc and stack
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load_ff <= 1'b0;
      pc_value_ff <= ext_ops_pkg::PC_RESET;
      stack_ff <= '0;
      wr_ff <= '0;
    end else begin
      pc_load_ff <= is_add_ret || is_call;
      if (is_add_ret) begin
        pc_value_ff <= i_top_of_return_stack; // [RULE_04]
      end else if (is_call) begin
        pc_value_ff <= call_target; // [RULE_08] [RULE_09] [RULE_11]
      end
      stack_ff.push <= is_call;
      stack_ff.push_val <= i_pc + ext_ops_pkg::PC_RET_STEP; // [RULE_07]
      stack_ff.pop <= is_add_ret; // [RULE_04]
      wr_ff.we <= is_second; // [RULE_14]
      wr_ff.addr <= i_instr_word[ext_ops_pkg::ADDR_MSB:0]; // [RULE_14] [RULE_15]
      wr_ff.data <= move_byte_ff;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_instr_taken = take || is_second;
  assign o_busy = !idle;
  assign o_pc_load = pc_load_ff;
  assign o_pc_value = pc_value_ff;
  assign o_stack_op = stack_ff;
  assign o_mem_rd.req = is_move && !src_indirect; // [RULE_17]
  assign o_mem_rd.addr = src_addr;
  assign o_mem_wr = wr_ff;
  assign o_fsr0 = ptr_ff[0];
  assign o_fsr1 = ptr_ff[1];
  assign o_software_stack_pointer = ptr_ff[2];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_cfg_gates_ops: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !cfg_sync_ff |-> !take) else $error("op taken with set disabled"); // [RULE_01]
  a_add_updates_ptr: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    is_add && ptr_sel == 2'h0 |=> ptr_ff[0] == $past(ptr_ff[0]) + $past(lit6))
    else $error("pointer add wrong"); // [RULE_02]
  a_add_stack_ptr: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    is_add_ret |=> ptr_ff[2] == $past(ptr_ff[2]) + $past(lit6))
    else $error("stack pointer add wrong"); // [RULE_03]
  a_ret_loads_pc: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    is_add_ret |=> o_pc_load && o_stack_op.pop && o_pc_value == $past(i_top_of_return_stack))
    else $error("return not taken"); // [RULE_04]
  a_two_cycle_ops: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (is_add_ret || is_call) |=> o_busy ##1 !o_busy)
    else $error("two-cycle op length wrong"); // [RULE_05]
  a_call_push: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    is_call |=> o_stack_op.push && o_stack_op.push_val == $past(i_pc) + 21'h000002)
    else $error("call push wrong"); // [RULE_07]
  a_call_target: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    is_call |=> o_pc_value[7:0] == $past(i_working_register)
    && o_pc_value[15:8] == $past(i_prog_counter_latch_high))
    else $error("call target wrong"); // [RULE_08]
  a_move_write: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    is_second |=> o_mem_wr.we && o_mem_wr.addr == $past(i_instr_word[11:0]))
    else $error("move write wrong"); // [RULE_14]
  a_indirect_zero: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    is_move && src_indirect |=> move_byte_ff == 8'h00)
    else $error("indirect source not zero"); // [RULE_17]

endmodule : stack_pointer_ext_ops
